// ### bench/cstd_clock_ctrl_test.sv
`timescale 1ns/10ps
`default_nettype none
module cstd_clock_ctrl_test;
   logic       i_clock, i_rst_n, i_clock_en, i_fast_crystal_osc, i_fast_internal_rc, i_slow_crystal_osc;
   logic       i_slow_internal_rc, i_trim_frequency_select, i_tick_source_bit, i_power_down;
   logic       i_powerdown_crystal_keep, i_clock_out_enable;
   logic [1:0] i_trim_loop_count_sel, i_trim_retry_limit, i_wdt_clock_sel, i_tmr0_clock_sel, i_tmr1_clock_sel;
   logic [1:0] i_spi_clock_sel, i_uart0_clock_sel, i_uart1_clock_sel, i_adc_clock_sel, i_crystal_enable_field;
   logic [2:0] i_core_clock_source_sel, i_tick_clock_source_sel;
   logic [3:0] i_clock_out_div_sel, o_source_running;
   logic [8:0] o_fast_rc_trim_code;
   logic       o_trim_lock_flag, o_trim_fail, o_core_clock, o_bus_clock, o_i2c_clock, o_pwm_clock, o_cmp_clock;
   logic       o_tick_clock, o_wdt_clock, o_tmr0_clock, o_tmr1_clock, o_spi_clock, o_uart0_clock, o_uart1_clock;
   logic       o_adc_clock, o_divided_clock_output_pin, o_fast_crystal_enable, o_fast_rc_enable;
   logic       o_slow_crystal_enable, o_slow_rc_enable;
   int         failures, n_compared, cyc, rc_half;
   int         exp_src [4] = '{80, 30, 20, 120};
   wire logic [9:0] mon;
   assign mon = {o_adc_clock, o_uart1_clock, o_spi_clock, o_tmr1_clock, o_tmr0_clock,
                 o_divided_clock_output_pin, o_uart0_clock, o_wdt_clock, o_tick_clock, o_core_clock};

   // Small target so that fast RC runs exactly four edges per crystal period
   cstd_clock_ctrl #(.TRIM_TARGET(4)) u_dut (
      .i_clock, .i_rst_n, .i_clock_en, .i_fast_crystal_osc, .i_fast_internal_rc, .i_slow_crystal_osc,
      .i_slow_internal_rc, .i_trim_frequency_select, .i_trim_loop_count_sel, .i_trim_retry_limit,
      .i_core_clock_source_sel, .i_tick_source_bit, .i_tick_clock_source_sel, .i_wdt_clock_sel,
      .i_tmr0_clock_sel, .i_tmr1_clock_sel, .i_spi_clock_sel, .i_uart0_clock_sel, .i_uart1_clock_sel,
      .i_adc_clock_sel, .i_power_down, .i_powerdown_crystal_keep, .i_crystal_enable_field,
      .i_clock_out_enable, .i_clock_out_div_sel, .o_fast_rc_trim_code, .o_trim_lock_flag, .o_trim_fail,
      .o_core_clock, .o_bus_clock, .o_i2c_clock, .o_pwm_clock, .o_cmp_clock, .o_tick_clock, .o_wdt_clock,
      .o_tmr0_clock, .o_tmr1_clock, .o_spi_clock, .o_uart0_clock, .o_uart1_clock, .o_adc_clock,
      .o_divided_clock_output_pin, .o_fast_crystal_enable, .o_fast_rc_enable, .o_slow_crystal_enable,
      .o_slow_rc_enable, .o_source_running
   );

   initial begin
      i_clock = 1'b0;
      forever #10 i_clock = ~i_clock;
   end

   // Periods 12, 8, 32, 48 clocks; phase locked so edge counts are exact
   always @(negedge i_clock) begin
      cyc <= cyc + 1;
      if (cyc % 6 == 0) i_fast_crystal_osc <= ~i_fast_crystal_osc;
      if (cyc % rc_half == 0) i_fast_internal_rc <= ~i_fast_internal_rc;
      if (cyc % 16 == 0) i_slow_crystal_osc <= ~i_slow_crystal_osc;
      if (cyc % 24 == 0) i_slow_internal_rc <= ~i_slow_internal_rc;
      if (cyc > 50000) begin
         failures++;
         close_out();
      end
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp, input int tol = 0);
      n_compared++;
      if (!(seen === exp || (tol > 0 && !$isunknown(seen) && seen + tol >= exp && seen <= exp + tol))) begin
         failures++;
         $display("CHECK FAILED %s expected %0d seen %0d", what, exp, seen);
      end
   endtask : check

   // Rising edges of one monitored clock over 960 cycles
   task automatic count(input int b, output int n);
      logic p;
      repeat (200) @(negedge i_clock);
      n = 0;
      p = mon[b];
      repeat (960) begin
         @(negedge i_clock);
         if (mon[b] === 1'b1 && p === 1'b0) n++;
         p = mon[b];
         if (b == 0) check("bus clocks", {o_bus_clock, o_i2c_clock, o_pwm_clock, o_cmp_clock}, {4{o_core_clock}});
      end
   endtask : count

   task automatic t_core();
      int n;
      check("running", o_source_running, 4'h0F);
      for (int s = 0; s < 5; s++) begin
         i_core_clock_source_sel = 3'(s % 4);
         count(0, n);
         check("core edges", n, exp_src[s % 4], 1);
      end
      $display("core select done");
   endtask : t_core

   task automatic t_div();
      int n;
      i_clock_out_enable = 1'b1;
      for (int d = 0; d < 3; d++) begin
         i_clock_out_div_sel = 4'(d);
         count(4, n);
         check("divided edges", n, 40 >> d, 1);
      end
      i_clock_out_enable = 1'b0;
      count(4, n);
      check("divided off", n, 0);
      i_clock_en = 1'b0;
      count(0, n);
      check("frozen core", n, 0);
      i_clock_en = 1'b1;
      $display("divider done");
   endtask : t_div

   task automatic t_tick();
      int n;
      i_tick_source_bit = 1'b0;
      for (int s = 3; s >= 0; s--) begin
         i_tick_clock_source_sel = 3'(s);
         count(1, n);
         check("ext tick edges", n, exp_src[s], 1);
      end
      i_tick_clock_source_sel = 3'h2;
      count(1, n);
      i_tick_source_bit = 1'b1;
      count(1, n);
      check("core tick edges", n, 80, 1);
      $display("tick done");
   endtask : t_tick

   task automatic t_periph();
      int n;
      i_uart0_clock_sel = 2'h1;
      count(3, n);
      check("uart fast rc", n, 120, 1);
      i_uart0_clock_sel = 2'h2;
      count(3, n);
      check("uart held", n, 120, 1);
      i_wdt_clock_sel = 2'h1;
      count(2, n);
      check("wdt held", n, 80, 1);
      i_wdt_clock_sel = 2'h2;
      count(2, n);
      check("wdt slow rc", n, 20, 1);
      count(5, n);
      check("tmr0 slow rc", n, 20, 1);
      count(6, n);
      check("tmr1 core", n, 80, 1);
      count(7, n);
      check("spi core", n, 80, 1);
      count(8, n);
      check("uart1 fast rc", n, 120, 1);
      count(9, n);
      check("adc fast rc", n, 120, 1);
      $display("peripheral select done");
   endtask : t_periph

   task automatic t_trim();
      i_trim_loop_count_sel = 2'h3;
      i_trim_retry_limit = 2'h3;
      i_trim_frequency_select = 1'b1;
      repeat (3000) @(negedge i_clock);
      check("lock", o_trim_lock_flag, 1'b1);
      check("fail", o_trim_fail, 1'b0);
      i_trim_frequency_select = 1'b0;
      repeat (4) @(negedge i_clock);
      check("lock off", o_trim_lock_flag, 1'b0);
      $display("trim done");
   endtask : t_trim

   task automatic t_pd();
      int n;
      i_power_down = 1'b1;
      for (int k = 0; k < 4; k++) begin
         i_powerdown_crystal_keep = k[0];
         i_crystal_enable_field = k[1] ? 2'h2 : 2'h1;
         repeat (2) @(negedge i_clock);
         check("pd enables", {o_fast_crystal_enable, o_fast_rc_enable, o_slow_rc_enable}, 3'h1);
         check("pd slow xtal", o_slow_crystal_enable, k == 3);
      end
      count(0, n);
      check("pd core", n, 0);
      count(3, n);
      check("pd uart", n, 0);
      count(2, n);
      check("pd wdt", n, 20, 1);
      count(5, n);
      check("pd tmr0", n, 20, 1);
      i_power_down = 1'b0;
      $display("power-down done");
   endtask : t_pd

   // Fast RC off target: every judge misses, eight misses end in failure
   task automatic t_trim_fail();
      rc_half = 5;
      i_trim_loop_count_sel = 2'h0;
      i_trim_retry_limit = 2'h0;
      i_trim_frequency_select = 1'b1;
      repeat (1500) @(negedge i_clock);
      check("trim fail", o_trim_fail, 1'b1);
      check("lock stays off", o_trim_lock_flag, 1'b0);
      check("trim code steps", o_fast_rc_trim_code, 9'h108);
      i_trim_frequency_select = 1'b0;
      repeat (2) @(negedge i_clock);
      check("fail cleared", o_trim_fail, 1'b0);
      $display("trim failure done");
   endtask : t_trim_fail

   task automatic close_out();
      $display("compared %0d mismatched %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : close_out

   initial begin
      {i_rst_n, i_fast_crystal_osc, i_fast_internal_rc, i_slow_crystal_osc, i_slow_internal_rc} = '0;
      {i_trim_frequency_select, i_tick_source_bit, i_power_down, i_powerdown_crystal_keep} = '0;
      {i_clock_out_enable, i_trim_loop_count_sel, i_trim_retry_limit, i_wdt_clock_sel} = '0;
      {i_core_clock_source_sel, i_tick_clock_source_sel, i_clock_out_div_sel, i_uart0_clock_sel} = '0;
      i_tmr0_clock_sel = 2'h2;
      i_tmr1_clock_sel = 2'h3;
      i_spi_clock_sel = 2'h3;
      i_uart1_clock_sel = 2'h1;
      i_adc_clock_sel = 2'h1;
      i_crystal_enable_field = 2'h1;
      i_clock_en = 1'b1;
      failures = 0;
      n_compared = 0;
      cyc = 0;
      rc_half = 4;
      repeat (10) @(negedge i_clock);
      check("trim code", o_fast_rc_trim_code, 9'h100);
      check("reset enables", {o_fast_crystal_enable, o_fast_rc_enable, o_slow_crystal_enable, o_slow_rc_enable}, 4'h1);
      i_rst_n = 1'b1;
      repeat (100) @(negedge i_clock);
      t_core();
      t_div();
      t_tick();
      t_periph();
      t_trim();
      t_pd();
      t_trim_fail();
      close_out();
   end
endmodule : cstd_clock_ctrl_test
`default_nettype wire

// ### rtl/cstd_clock_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module cstd_clock_ctrl #(
   parameter int unsigned TRIM_TARGET = cstd_pkg::TRIM_TARGET
) (
   // Clock, reset, enable
   input  wire logic       i_clock,
   input  wire logic       i_rst_n,
   input  wire logic       i_clock_en,
   // Oscillator pins
   input  wire logic       i_fast_crystal_osc,
   input  wire logic       i_fast_internal_rc,
   input  wire logic       i_slow_crystal_osc,
   input  wire logic       i_slow_internal_rc,
   // Trim control
   input  wire logic       i_trim_frequency_select,
   input  wire logic [1:0] i_trim_loop_count_sel,
   input  wire logic [1:0] i_trim_retry_limit,
   // Source selects
   input  wire logic [2:0] i_core_clock_source_sel,
   input  wire logic       i_tick_source_bit,
   input  wire logic [2:0] i_tick_clock_source_sel,
   input  wire logic [1:0] i_wdt_clock_sel,
   input  wire logic [1:0] i_tmr0_clock_sel,
   input  wire logic [1:0] i_tmr1_clock_sel,
   input  wire logic [1:0] i_spi_clock_sel,
   input  wire logic [1:0] i_uart0_clock_sel,
   input  wire logic [1:0] i_uart1_clock_sel,
   input  wire logic [1:0] i_adc_clock_sel,
   // Power control
   input  wire logic       i_power_down,
   input  wire logic       i_powerdown_crystal_keep,
   input  wire logic [1:0] i_crystal_enable_field,
   // Divided clock output
   input  wire logic       i_clock_out_enable,
   input  wire logic [3:0] i_clock_out_div_sel,
   // Trim status
   output logic [8:0]      o_fast_rc_trim_code,
   output logic            o_trim_lock_flag,
   output logic            o_trim_fail,
   // Clocks
   output logic            o_core_clock,
   output logic            o_bus_clock,
   output logic            o_i2c_clock,
   output logic            o_pwm_clock,
   output logic            o_cmp_clock,
   output logic            o_tick_clock,
   output logic            o_wdt_clock,
   output logic            o_tmr0_clock,
   output logic            o_tmr1_clock,
   output logic            o_spi_clock,
   output logic            o_uart0_clock,
   output logic            o_uart1_clock,
   output logic            o_adc_clock,
   output logic            o_divided_clock_output_pin,
   // Oscillator enables and status
   output logic            o_fast_crystal_enable,
   output logic            o_fast_rc_enable,
   output logic            o_slow_crystal_enable,
   output logic            o_slow_rc_enable,
   output logic [3:0]      o_source_running
);
   // Pins sampled by 50 MHz: sources must stay below half that rate
   logic [3:0] sync1_q, sync2_q, sync3_q;
   logic [3:0] osc_rise;
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         sync1_q <= 4'h0;
         sync2_q <= 4'h0;
         sync3_q <= 4'h0;
      end else if (i_clock_en) begin
         sync1_q <= {i_fast_internal_rc, i_slow_internal_rc, i_slow_crystal_osc, i_fast_crystal_osc};
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
      end
   end
   assign osc_rise = sync2_q & ~sync3_q;
   // Activity watch: no edge for the stall time means dead
   logic [cstd_pkg::STALL_W-1:0] stall_q [4];
   logic [cstd_pkg::STALL_W-1:0] stall_d [4];
   logic [3:0]                   run_q, run_d;
   localparam logic [cstd_pkg::STALL_W-1:0] STALL_MAX = cstd_pkg::STALL_W'(cstd_pkg::STALL_CYCLES);
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         stall_d[i] = (sync2_q[i] != sync3_q[i]) ? '0 :
                      (stall_q[i] == STALL_MAX) ? stall_q[i] : stall_q[i] + 1'b1;
         run_d[i]   = (stall_d[i] != STALL_MAX);
      end
   end
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         for (int i = 0; i < 4; i++) stall_q[i] <= STALL_MAX;
         run_q <= 4'h0;
      end else if (i_clock_en) begin
         stall_q <= stall_d;
         run_q   <= run_d;
      end
   end
   assign o_source_running = run_q;
   // Core clock, stopped in power-down
   cstd_mux_if core_if ();
   assign core_if.src  = {sync2_q[3], sync2_q[2], sync2_q[1], sync2_q[0]};
   assign core_if.run  = run_q;
   assign core_if.sel  = i_core_clock_source_sel;
   assign core_if.stop = i_power_down;
   cstd_glitch_mux #(.ALLOWED(4'hF)) u_core_mux (
      .i_clock    (i_clock),
      .i_rst_n    (i_rst_n),
      .i_clock_en (i_clock_en),
      .m          (core_if.mux)
   );
   // Bus and fixed peripherals share the one core flop
   assign o_core_clock = core_if.clk_out;
   assign o_bus_clock  = core_if.clk_out;
   assign o_i2c_clock  = core_if.clk_out;
   assign o_pwm_clock  = core_if.clk_out;
   assign o_cmp_clock  = core_if.clk_out;
   // External tick clock, then tick source pick
   cstd_mux_if ext_if ();
   cstd_mux_if tick_if ();
   assign ext_if.src  = sync2_q;
   assign ext_if.run  = run_q;
   assign ext_if.sel  = i_tick_clock_source_sel;
   assign ext_if.stop = i_power_down;
   cstd_glitch_mux #(.ALLOWED(4'hF)) u_ext_tick_mux (
      .i_clock    (i_clock),
      .i_rst_n    (i_rst_n),
      .i_clock_en (i_clock_en),
      .m          (ext_if.mux)
   );
   assign tick_if.src  = {2'b00, core_if.clk_out, ext_if.clk_out};
   assign tick_if.run  = {2'b00, core_if.running, ext_if.running};
   assign tick_if.sel  = {2'b00, i_tick_source_bit};
   assign tick_if.stop = i_power_down;
   cstd_glitch_mux #(.ALLOWED(4'h3)) u_tick_mux (
      .i_clock    (i_clock),
      .i_rst_n    (i_rst_n),
      .i_clock_en (i_clock_en),
      .m          (tick_if.mux)
   );
   assign o_tick_clock = tick_if.clk_out;
   // Peripheral muxes; ext crystal follows the enabled crystal
   logic       ext_xtal, ext_xtal_run;
   logic [1:0] per_sel [cstd_pkg::NUM_PERIPH];
   assign ext_xtal     = (i_crystal_enable_field == cstd_pkg::XTAL_SLOW_ON) ? sync2_q[1] : sync2_q[0];
   assign ext_xtal_run = (i_crystal_enable_field == cstd_pkg::XTAL_SLOW_ON) ? run_q[1] : run_q[0];
   assign per_sel = '{i_wdt_clock_sel, i_tmr0_clock_sel, i_tmr1_clock_sel, i_spi_clock_sel,
                      i_uart0_clock_sel, i_uart1_clock_sel, i_adc_clock_sel};
   cstd_mux_if per_if [cstd_pkg::NUM_PERIPH] ();
   logic [cstd_pkg::NUM_PERIPH-1:0] per_clk;
   for (genvar g = 0; g < cstd_pkg::NUM_PERIPH; g++) begin : g_periph
      assign per_if[g].src  = {core_if.clk_out, sync2_q[2], sync2_q[3], ext_xtal};
      assign per_if[g].run  = {core_if.running, run_q[2], run_q[3], ext_xtal_run};
      assign per_if[g].sel  = {1'b0, per_sel[g]};
      // Slow RC users stay alive through power-down
      assign per_if[g].stop = i_power_down &
                              !(cstd_pkg::PD_KEEP_MASK[g] && per_sel[g] == cstd_pkg::SRC_SLOW_RC);
      cstd_glitch_mux #(.ALLOWED(cstd_pkg::PERIPH_MASKS[4*g +: 4])) u_per_mux (
         .i_clock    (i_clock),
         .i_rst_n    (i_rst_n),
         .i_clock_en (i_clock_en),
         .m          (per_if[g].mux)
      );
      assign per_clk[g] = per_if[g].clk_out;
   end
   assign o_wdt_clock   = per_clk[0];
   assign o_tmr0_clock  = per_clk[1];
   assign o_tmr1_clock  = per_clk[2];
   assign o_spi_clock   = per_clk[3];
   assign o_uart0_clock = per_clk[4];
   assign o_uart1_clock = per_clk[5];
   assign o_adc_clock   = per_clk[6];
   // Oscillator enables
   logic [3:0] osc_en_q, osc_en_d;
   logic       slow_xtal_keep;
   always_comb begin
      slow_xtal_keep = i_powerdown_crystal_keep && (i_crystal_enable_field == cstd_pkg::XTAL_SLOW_ON);
      osc_en_d[0] = !i_power_down && (i_crystal_enable_field == cstd_pkg::XTAL_FAST_ON);
      osc_en_d[1] = i_power_down ? slow_xtal_keep
                                 : (i_crystal_enable_field == cstd_pkg::XTAL_SLOW_ON);
      osc_en_d[2] = 1'b1;
      osc_en_d[3] = !i_power_down;
   end
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) osc_en_q <= 4'h4;
      else if (i_clock_en) osc_en_q <= osc_en_d;
   end
   assign o_fast_crystal_enable = osc_en_q[0];
   assign o_slow_crystal_enable = osc_en_q[1];
   assign o_slow_rc_enable      = osc_en_q[2];
   assign o_fast_rc_enable      = osc_en_q[3];
   // Divider fed by core clock rising edges
   logic [cstd_pkg::DIV_STAGES-1:0] div_q, div_d;
   logic                            core_prev_q, divided_clock_output_pin_q, divided_clock_output_pin_d;
   always_comb begin
      div_d  = div_q;
      if (core_if.clk_out && !core_prev_q) div_d = div_q + 1'b1;
      divided_clock_output_pin_d = i_clock_out_enable & div_d[i_clock_out_div_sel];
   end
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         div_q       <= '0;
         core_prev_q <= 1'b0;
         divided_clock_output_pin_q      <= 1'b0;
      end else if (i_clock_en) begin
         div_q       <= div_d;
         core_prev_q <= core_if.clk_out;
         divided_clock_output_pin_q      <= divided_clock_output_pin_d;
      end
   end
   assign o_divided_clock_output_pin = divided_clock_output_pin_q;

   // Auto trim: count fast RC edges over a window of crystal periods
   localparam logic [cstd_pkg::TRIM_CNT_W-1:0] TGT = cstd_pkg::TRIM_CNT_W'(TRIM_TARGET);
   cstd_pkg::cstd_trim_e             tst_q, tst_d;
   logic [cstd_pkg::TRIM_CNT_W-1:0]  fcnt_q, fcnt_d, goal, tol;
   logic [5:0]                       xcnt_q, xcnt_d, periods;
   logic [6:0]                       upd_q, upd_d, upd_lim;
   logic [8:0]                       code_q, code_d;
   logic                             lock_q, lock_d, fail_q, fail_d;
   always_comb begin
      periods = 6'(cstd_pkg::TRIM_PERIODS_MIN) << i_trim_loop_count_sel;
      upd_lim = 7'(cstd_pkg::TRIM_UPDATES_MIN) << i_trim_retry_limit;
      goal    = TGT << i_trim_loop_count_sel << 2;
      tol     = cstd_pkg::TRIM_CNT_W'(goal * cstd_pkg::LOCK_TOL_PCT / 100);
      tst_d   = tst_q;
      fcnt_d  = fcnt_q;
      xcnt_d  = xcnt_q;
      upd_d   = upd_q;
      code_d  = code_q;
      lock_d  = lock_q;
      fail_d  = fail_q;
      unique case (tst_q)
         cstd_pkg::CSTD_TRIM_IDLE: begin
            fcnt_d = '0;
            xcnt_d = '0;
            if (i_trim_frequency_select && !fail_q && run_q[1] && osc_rise[1])
               tst_d = cstd_pkg::CSTD_TRIM_COUNT;
         end
         cstd_pkg::CSTD_TRIM_COUNT: begin
            fcnt_d = fcnt_q + {15'h0, osc_rise[3]};
            xcnt_d = xcnt_q + {5'h0, osc_rise[1]};
            if (xcnt_d == periods) tst_d = cstd_pkg::CSTD_TRIM_JUDGE;
         end
         cstd_pkg::CSTD_TRIM_JUDGE: begin
            fcnt_d = '0;
            xcnt_d = '0;
            tst_d  = cstd_pkg::CSTD_TRIM_COUNT;
            if ((fcnt_q <= goal + tol) && (fcnt_q + tol >= goal)) begin
               lock_d = 1'b1;
               upd_d  = '0;
            end else begin
               lock_d = 1'b0;
               code_d = (fcnt_q > goal) ? code_q - 1'b1 : code_q + 1'b1;
               upd_d  = upd_q + 1'b1;
               if (upd_d == upd_lim) begin
                  fail_d = 1'b1;
                  tst_d  = cstd_pkg::CSTD_TRIM_IDLE;
               end
            end
         end
         default: tst_d = cstd_pkg::CSTD_TRIM_IDLE;
      endcase
      // Dead crystal or trim off voids the reference
      if (!i_trim_frequency_select || !run_q[1]) begin
         tst_d  = cstd_pkg::CSTD_TRIM_IDLE;
         lock_d = 1'b0;
         upd_d  = '0;
      end
      if (!i_trim_frequency_select) fail_d = 1'b0;
   end
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         tst_q  <= cstd_pkg::CSTD_TRIM_IDLE;
         fcnt_q <= '0;
         xcnt_q <= '0;
         upd_q  <= '0;
         code_q <= cstd_pkg::TRIM_CODE_RST;
         lock_q <= 1'b0;
         fail_q <= 1'b0;
      end else if (i_clock_en) begin
         tst_q  <= tst_d;
         fcnt_q <= fcnt_d;
         xcnt_q <= xcnt_d;
         upd_q  <= upd_d;
         code_q <= code_d;
         lock_q <= lock_d;
         fail_q <= fail_d;
      end
   end
   assign o_fast_rc_trim_code = code_q;
   assign o_trim_lock_flag    = lock_q;
   assign o_trim_fail         = fail_q;

   // Checks
   sequence judged_off_s;
      i_clock_en && tst_q == cstd_pkg::CSTD_TRIM_JUDGE && i_trim_frequency_select && run_q[1]
         && (fcnt_q > goal + tol || fcnt_q + tol < goal);
   endsequence
   lock_drop_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      judged_off_s |=> !o_trim_lock_flag)
      else $error("lock held after an out of range count");
   trim_off_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (i_clock_en && !i_trim_frequency_select) |=> !o_trim_lock_flag && tst_q == cstd_pkg::CSTD_TRIM_IDLE)
      else $error("trim kept running while disabled");
   pd_fast_off_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (i_clock_en && i_power_down) |=> !o_fast_rc_enable && !o_fast_crystal_enable && o_slow_rc_enable)
      else $error("fast sources not halted in power-down");
   pd_xtal_keep_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (i_clock_en && i_power_down) |=> o_slow_crystal_enable == $past(slow_xtal_keep))
      else $error("slow crystal enable wrong in power-down");
   pd_core_stop_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (i_clock_en && i_power_down && !o_core_clock) ##1 (i_clock_en && i_power_down)[*2] |-> !o_core_clock)
      else $error("core clock ran in power-down");
   divided_clock_output_pin_stage_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (i_clock_en && i_clock_out_enable) |=> o_divided_clock_output_pin == div_q[$past(i_clock_out_div_sel)])
      else $error("clock output not from selected stage");
   div_step_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (i_clock_en && o_core_clock && !core_prev_q) |=> div_q == $past(div_q) + 16'h0001)
      else $error("divider missed a core clock edge");
endmodule : cstd_clock_ctrl
`default_nettype wire

// ### rtl/cstd_glitch_mux.sv
`timescale 1ns/10ps
`default_nettype none
module cstd_glitch_mux #(
   parameter logic [3:0] ALLOWED = 4'hF
) (
   // Clock and reset
   input  wire logic  i_clock,
   input  wire logic  i_rst_n,
   input  wire logic  i_clock_en,
   // Sources and output
   cstd_mux_if.mux    m
);
   logic [1:0] cur_q, cur_d;
   logic       out_q, out_d;
   logic       prev_q, prev_d;
   logic [1:0] req;
   logic       req_ok;

   always_comb begin
      req    = m.sel[1:0];
      req_ok = (m.sel[2] == 1'b0) && ALLOWED[req];
      cur_d  = cur_q;
      out_d  = out_q;
      prev_d = m.src[cur_q];
      // Hand over only at a common low phase of two live clocks
      if (req_ok && (req != cur_q) && m.run[cur_q] && m.run[req] &&
          !m.src[cur_q] && !m.src[req] && !out_q) begin
         cur_d  = req;
         prev_d = 1'b0;
      end else if (m.stop) begin
         out_d = out_q & m.src[cur_q];
      end else if (!out_q) begin
         // Rise only on a true edge, never mid-pulse
         out_d = m.src[cur_q] & !prev_q;
      end else begin
         out_d = m.src[cur_q];
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         cur_q  <= 2'h0;
         out_q  <= 1'b0;
         prev_q <= 1'b0;
      end else if (i_clock_en) begin
         cur_q  <= cur_d;
         out_q  <= out_d;
         prev_q <= prev_d;
      end
   end

   assign m.clk_out = out_q;
   assign m.running = m.run[cur_q] & ~m.stop;

   sequence switch_seen_s;
      i_clock_en && (cur_d != cur_q);
   endsequence
   handover_at_low_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      switch_seen_s |=> !out_q && !prev_q)
      else $error("mux handed over outside a low phase");
   rise_on_edge_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      $rose(out_q) |-> !$past(prev_q))
      else $error("mux output rose in the middle of a pulse");
   stop_stays_low_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (m.stop && !out_q) ##1 m.stop |-> !out_q)
      else $error("stopped clock output came back high");
endmodule : cstd_glitch_mux
`default_nettype wire

// ### rtl/cstd_mux_if.sv
`timescale 1ns/10ps
`default_nettype none
interface cstd_mux_if;
   logic [3:0] src;
   logic [3:0] run;
   logic [2:0] sel;
   logic       stop;
   logic       clk_out;
   logic       running;
   modport ctrl (output src, run, sel, stop, input clk_out, running);
   modport mux  (input src, run, sel, stop, output clk_out, running);
endinterface : cstd_mux_if
`default_nettype wire

// ### rtl/cstd_pkg.sv
package cstd_pkg;
   // Timing
   localparam int unsigned CLOCK_PERIOD_NS = 20;
   localparam int unsigned STALL_TIME_NS   = 80_000;
   localparam int unsigned STALL_CYCLES    = STALL_TIME_NS / CLOCK_PERIOD_NS;
   localparam int unsigned STALL_W         = 12;
   // Trim reference
   localparam int unsigned FAST_RC_HZ      = 48_000_000;
   localparam int unsigned XTAL_HZ         = 32_768;
   localparam int unsigned TRIM_TARGET     = (FAST_RC_HZ + XTAL_HZ / 2) / XTAL_HZ;
   localparam int unsigned LOCK_TOL_PCT    = 1;
   localparam int unsigned TRIM_PERIODS_MIN = 4;
   localparam int unsigned TRIM_UPDATES_MIN = 8;
   localparam int unsigned TRIM_CNT_W      = 16;
   localparam int unsigned TRIM_W          = 9;
   localparam logic [8:0]  TRIM_CODE_RST   = 9'h100;
   // Source codes of the shared source vector
   localparam logic [1:0]  SRC_EXT_XTAL    = 2'h0;
   localparam logic [1:0]  SRC_FAST_RC     = 2'h1;
   localparam logic [1:0]  SRC_SLOW_RC     = 2'h2;
   localparam logic [1:0]  SRC_CORE        = 2'h3;
   // Core and tick source order
   localparam logic [1:0]  OSC_FAST_XTAL   = 2'h0;
   localparam logic [1:0]  OSC_SLOW_XTAL   = 2'h1;
   localparam logic [1:0]  OSC_SLOW_RC     = 2'h2;
   localparam logic [1:0]  OSC_FAST_RC     = 2'h3;
   // Crystal enable field codes
   localparam logic [1:0]  XTAL_FAST_ON    = 2'h1;
   localparam logic [1:0]  XTAL_SLOW_ON    = 2'h2;
   // Peripheral source masks: wdt, tmr0, tmr1, spi, uart0, uart1, adc
   localparam int unsigned NUM_PERIPH      = 7;
   localparam logic [27:0] PERIPH_MASKS    = 28'hB_33_9_FF_D;
   localparam logic [6:0]  PD_KEEP_MASK    = 7'h07;
   // Divider
   localparam int unsigned DIV_STAGES      = 16;
   typedef enum logic [1:0] {CSTD_TRIM_IDLE, CSTD_TRIM_COUNT, CSTD_TRIM_JUDGE} cstd_trim_e;
endpackage : cstd_pkg
